// ---- verilog/port_cfg_pkg.sv ----
// constants for the per-port link and mac configuration bank
// assumes byte-wide register port, port number in address bits 15:12
package port_cfg_pkg;
   localparam logic [11:0] OFS_PHY_CTRL_LO = 12'h13e;
   localparam logic [11:0] OFS_PHY_CTRL_HI = 12'h13f;
   localparam logic [11:0] OFS_EXT_CTRL0   = 12'h300;
   localparam logic [11:0] OFS_EXT_CTRL1   = 12'h301;
   localparam logic [11:0] OFS_MAC_CTRL0   = 12'h400;
   localparam logic [11:0] OFS_MAC_CTRL1   = 12'h401;
   localparam logic [3:0]  EXT_WIN_HI      = 4'h3;
   localparam logic [3:0]  MAC_WIN_HI      = 4'h4;
   // field positions
   localparam int BIT_JABBER   = 9;
   localparam int BIT_SPD100   = 5;
   localparam int BIT_SPD10    = 4;
   localparam int BIT_DUPLEX   = 3;
   localparam int BIT_MDUPLEX  = 6;
   localparam int BIT_TXFC     = 5;
   localparam int BIT_SEL100   = 4;
   localparam int BIT_RXFC     = 3;
   localparam int BIT_GIGSEL   = 6;
   localparam int BIT_RXDLY    = 4;
   localparam int BIT_TXDLY    = 3;
   localparam int BIT_CLKDIR   = 2;
   localparam int BIT_STORM    = 1;
   localparam int BIT_JUMBO    = 0;
   localparam int BIT_BACKPR   = 3;
   localparam int BIT_PASSALL  = 0;
   // reset values of the non-strap parts
   localparam logic [15:0] RST_PHY_CTRL = 16'h0300;
   localparam logic [7:0]  RST_EXT0     = 8'h50;
   localparam logic [7:0]  RST_EXT1     = 8'h08;
   localparam logic [7:0]  RST_MAC0     = 8'h00;
   localparam logic [7:0]  RST_MAC1     = 8'h00;
   // writable masks; other bits read-only
   localparam logic [15:0] WM_PHY  = 16'hf380;
   localparam logic [7:0]  WM_EXT0 = 8'h7f;
   localparam logic [7:0]  WM_EXT1 = 8'hff;
   localparam logic [7:0]  WM_MAC0 = 8'h0b;
   localparam logic [7:0]  WM_MAC1 = 8'hbf;
   // payload limits
   localparam logic [13:0] PAYLOAD_STD   = 14'd1500;
   localparam logic [13:0] PAYLOAD_JUMBO = 14'd9000;
   // strap capture delay after reset release, in cycles; the three-stage
   // synchroniser shows a pin level only after its fourth edge
   localparam int STRAP_SYNC_CYC = 4;
   // cycles our own clock needs to drain out of the pin synchroniser
   localparam int PIN_SETTLE_CYC = 6;
   localparam logic [1:0] IF_RGMII = 2'b00;
   localparam logic [1:0] IF_RMII  = 2'b01;
   // rmii reference from the system clock: toggled on every rising mclk edge, so mclk/2
   localparam int REFCLK_DIV = 1;
endpackage : port_cfg_pkg

// ---- verilog/pin_sync.sv ----
// three-stage synchroniser for a bus of pins
// a change is taken once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         srst,
   // pins and result
   input  wire logic [W-1:0] pin,
   output var  logic [W-1:0] level
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] level_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge mclk) begin
            if (srst) begin
               s1_q[i]    <= 1'b0;
               s2_q[i]    <= 1'b0;
               s3_q[i]    <= 1'b0;
               level_q[i] <= 1'b0;
            end else begin
               s1_q[i] <= pin[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i]) begin
                  level_q[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate

   assign level = level_q;
endmodule : pin_sync
`default_nettype wire

// ---- verilog/edge_detect.sv ----
// finds rising edges of an already synchronised level
// assumes input is stable in the mclk domain
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
   // clock and reset
   input  wire logic mclk,
   input  wire logic srst,
   // level in, one-cycle pulse out
   input  wire logic level,
   output var  logic rise
);
   logic prev_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end

   assign rise = level & ~prev_q;
endmodule : edge_detect
`default_nettype wire

// ---- verilog/port_link_mac_config.sv ----
// per-port configuration bank: copper transceiver control, external mac
// interface control and switch mac control, byte-wide register port
// assumes straps are static pins, sampled after reset release
`timescale 1ns/1ps
`default_nettype none
module port_link_mac_config
   import port_cfg_pkg::*;
#(
   parameter logic [3:0] PORT_NUM = 4'h6,
   parameter bit         HAS_PHY  = 1'b0,
   parameter bit         HAS_EXT  = 1'b1
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // register port
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output var  logic [7:0]  rdata,
   // transceiver resolved status
   input  wire logic        phy_res_100,
   input  wire logic        phy_res_10,
   input  wire logic        phy_res_full,
   // configuration straps
   input  wire logic        flow_control_default_strap,
   input  wire logic        port_speed_strap,
   input  wire logic        port_clock_dir_strap,
   input  wire logic [1:0]  port_iface_type_strap,
   // receive clock pin, three signals
   input  wire logic        receive_clock_pin_in,
   output var  logic        receive_clock_pin_out,
   output var  logic        receive_clock_pin_oe_n,
   // frame classification from the receive path
   input  wire logic        frame_bad,
   input  wire logic        frame_is_flow_ctrl,
   input  wire logic        flow_ctrl_filter_en,
   input  wire logic [13:0] frame_payload_len,
   // controls to the datapath
   output var  logic        jabber_enable,
   output var  logic        mac_full_duplex,
   output var  logic        tx_flow_enable,
   output var  logic        rx_flow_enable,
   output var  logic [1:0]  link_speed,
   output var  logic        rx_clock_delay_enable,
   output var  logic        tx_clock_delay_enable,
   output var  logic [1:0]  iface_type,
   output var  logic        clocks_from_partner,
   output var  logic        storm_protect_en,
   output var  logic [13:0] payload_limit,
   output var  logic        back_pressure_en,
   output var  logic        frame_drop,
   output var  logic        frame_mirror_only,
   output var  logic        link_clk_seen
);
   // registers
   logic [15:0] phy_ctrl_q;
   logic [7:0]  ext0_q;
   logic [7:0]  ext1_q;
   logic [7:0]  mac0_q;
   logic [7:0]  mac1_q;
   logic [7:0]  rdata_q;
   logic [2:0]  strap_cnt_q;
   logic        strap_done_q;
   logic        refclk_q;
   logic        seen_q;
   logic [2:0]  hold_q;
   logic [2:0]  stat_q;

   // outputs registered
   logic        jab_q;
   logic        dup_q;
   logic        txfc_q;
   logic        rxfc_q;
   logic [1:0]  spd_q;
   logic        rxd_q;
   logic        txd_q;
   logic [1:0]  ift_q;
   logic        cfp_q;
   logic        storm_q;
   logic [13:0] plim_q;
   logic        bp_q;
   logic        drop_q;
   logic        mir_q;
   logic        rcout_q;
   logic        rcoe_n_q;

   // synchronised pins
   logic [4:0]  strap_lvl;
   logic        rxc_lvl;
   logic        rxc_rise;

   pin_sync #(.W(5)) u_strap_sync (
      .mclk  (mclk),
      .srst  (srst),
      .pin   ({flow_control_default_strap, port_speed_strap, port_clock_dir_strap, port_iface_type_strap}),
      .level (strap_lvl)
   );

   pin_sync #(.W(1)) u_rxc_sync (
      .mclk  (mclk),
      .srst  (srst),
      .pin   (receive_clock_pin_in),
      .level (rxc_lvl)
   );

   edge_detect u_rxc_edge (
      .mclk  (mclk),
      .srst  (srst),
      .level (rxc_lvl),
      .rise  (rxc_rise)
   );

   // address decode
   wire       in_port   = (addr[15:12] == PORT_NUM);
   wire [11:0] ofs      = addr[11:0];
   wire       sel_phy_l = in_port && HAS_PHY && (ofs == OFS_PHY_CTRL_LO);
   wire       sel_phy_h = in_port && HAS_PHY && (ofs == OFS_PHY_CTRL_HI);
   wire       sel_ext0  = in_port && HAS_EXT && (ofs[11:8] == EXT_WIN_HI) && (ofs == OFS_EXT_CTRL0);
   wire       sel_ext1  = in_port && HAS_EXT && (ofs[11:8] == EXT_WIN_HI) && (ofs == OFS_EXT_CTRL1);
   wire       sel_mac0  = in_port && (ofs[11:8] == MAC_WIN_HI) && (ofs == OFS_MAC_CTRL0);
   wire       sel_mac1  = in_port && (ofs[11:8] == MAC_WIN_HI) && (ofs == OFS_MAC_CTRL1);

   // live status folded into the read view of the phy register
   wire [15:0] phy_view = {phy_ctrl_q[15:12], 2'b00, phy_ctrl_q[9:7], 1'b0,
                           stat_q[2], stat_q[1], stat_q[0], 3'b000};

   wire [7:0] rd_mux = sel_phy_h ? phy_view[15:8] :
                       sel_phy_l ? phy_view[7:0]  :
                       sel_ext0  ? {1'b0, ext0_q[6:0]} :
                       sel_ext1  ? ext1_q :
                       sel_mac0  ? {4'h0, mac0_q[3], 1'b0, mac0_q[1:0]} :
                       sel_mac1  ? {mac1_q[7], 1'b0, mac1_q[5:0]} :
                       8'h00;

   // masked writes keep read-only bits untouched
   wire [7:0] phy_lo_d = (phy_ctrl_q[7:0] & ~WM_PHY[7:0]) | (wdata & WM_PHY[7:0]);
   wire [7:0] phy_hi_d = (phy_ctrl_q[15:8] & ~WM_PHY[15:8]) | (wdata & WM_PHY[15:8]);
   wire [7:0] ext0_d   = (ext0_q & ~WM_EXT0) | (wdata & WM_EXT0);
   wire [7:0] ext1_d   = (ext1_q & ~WM_EXT1) | (wdata & WM_EXT1);
   wire [7:0] mac0_d   = (mac0_q & ~WM_MAC0) | (wdata & WM_MAC0);
   wire [7:0] mac1_d   = (mac1_q & ~WM_MAC1) | (wdata & WM_MAC1);

   // straps land once, a few cycles after release, so synchroniser has settled
   wire strap_load = !strap_done_q && (strap_cnt_q == 3'(STRAP_SYNC_CYC));

   always_ff @(posedge mclk) begin
      if (srst) begin
         strap_cnt_q  <= 3'd0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_cnt_q  <= strap_cnt_q + 3'd1;
         strap_done_q <= strap_load;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         phy_ctrl_q <= RST_PHY_CTRL;
      end else if (wr && sel_phy_l) begin
         phy_ctrl_q[7:0] <= phy_lo_d;
      end else if (wr && sel_phy_h) begin
         phy_ctrl_q[15:8] <= phy_hi_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ext0_q <= RST_EXT0;
      end else if (strap_load) begin
         ext0_q[BIT_TXFC] <= strap_lvl[4];
         ext0_q[BIT_RXFC] <= strap_lvl[4];
      end else if (wr && sel_ext0) begin
         ext0_q <= ext0_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ext1_q <= RST_EXT1;
      end else if (strap_load) begin
         ext1_q[BIT_GIGSEL] <= strap_lvl[3];
         ext1_q[BIT_CLKDIR] <= strap_lvl[2];
         ext1_q[1:0]        <= strap_lvl[1:0];
      end else if (wr && sel_ext1) begin
         ext1_q <= ext1_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         mac0_q <= RST_MAC0;
         mac1_q <= RST_MAC1;
      end else begin
         if (wr && sel_mac0) begin
            mac0_q <= mac0_d;
         end
         if (wr && sel_mac1) begin
            mac1_q <= mac1_d;
         end
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd ? rd_mux : 8'h00;
      end
   end

   // status inputs are already in the mclk domain
   always_ff @(posedge mclk) begin
      if (srst) begin
         stat_q <= 3'b000;
      end else begin
         stat_q <= {phy_res_100, phy_res_10, phy_res_full};
      end
   end

   // interface decode
   wire is_rgmii   = (ext1_q[1:0] == IF_RGMII);
   wire is_rmii    = (ext1_q[1:0] == IF_RMII);
   wire is_mii     = ext1_q[1];
   wire gig_sel    = is_rgmii && !ext1_q[BIT_GIGSEL];
   // 2'b10 gig, 2'b01 hundred, 2'b00 ten; bit 4 ignored at gigabit
   wire [1:0] spd_d = gig_sel ? 2'b10 : (ext0_q[BIT_SEL100] ? 2'b01 : 2'b00);
   wire partner_clk = ext1_q[BIT_CLKDIR];
   // we drive the receive clock pin as a phy-side mii or as rmii reference source
   wire drive_rxc   = !partner_clk && (is_mii || is_rmii);
   wire half_dup    = !ext0_q[BIT_MDUPLEX];

   // frame disposition; flow-control frames follow the switch filter only
   wire oversize    = frame_payload_len > plim_q;
   wire is_bad      = frame_bad || oversize;
   wire fc_drop     = frame_is_flow_ctrl && flow_ctrl_filter_en;
   wire drop_d      = fc_drop || (is_bad && !frame_is_flow_ctrl && !mac1_q[BIT_PASSALL]);
   wire mir_d       = is_bad && !frame_is_flow_ctrl && mac1_q[BIT_PASSALL];

   always_ff @(posedge mclk) begin
      if (srst) begin
         jab_q    <= 1'b1;
         dup_q    <= 1'b1;
         txfc_q   <= 1'b0;
         rxfc_q   <= 1'b0;
         spd_q    <= 2'b01;
         rxd_q    <= 1'b0;
         txd_q    <= 1'b1;
         ift_q    <= IF_RGMII;
         cfp_q    <= 1'b1;
         storm_q  <= 1'b0;
         plim_q   <= PAYLOAD_STD;
         bp_q     <= 1'b0;
         drop_q   <= 1'b0;
         mir_q    <= 1'b0;
         rcoe_n_q <= 1'b1;
      end else begin
         jab_q    <= phy_ctrl_q[BIT_JABBER];
         dup_q    <= ext0_q[BIT_MDUPLEX];
         txfc_q   <= ext0_q[BIT_TXFC];
         rxfc_q   <= ext0_q[BIT_RXFC];
         spd_q    <= spd_d;
         rxd_q    <= is_rgmii && ext1_q[BIT_RXDLY];
         txd_q    <= is_rgmii && ext1_q[BIT_TXDLY];
         ift_q    <= ext1_q[1:0];
         cfp_q    <= partner_clk;
         storm_q  <= mac0_q[BIT_STORM];
         plim_q   <= mac0_q[BIT_JUMBO] ? PAYLOAD_JUMBO : PAYLOAD_STD;
         bp_q     <= mac1_q[BIT_BACKPR] && half_dup;
         drop_q   <= drop_d;
         mir_q    <= mir_d;
         rcoe_n_q <= !drive_rxc;
      end
   end

   // generated clock: mclk/2 toward the pin; a real part needs a pll for 50 MHz
   always_ff @(posedge mclk) begin
      if (srst) begin
         refclk_q <= 1'b0;
         rcout_q  <= 1'b0;
      end else begin
         refclk_q <= drive_rxc ? ~refclk_q : 1'b0;
         rcout_q  <= refclk_q;
      end
   end

   // our own toggles still sit in the pin synchroniser after we let go of the pin;
   // edges are ignored until they drain, so only the partner can set the flag
   wire hold_busy = (hold_q != 3'd0);

   always_ff @(posedge mclk) begin
      if (srst) begin
         hold_q <= 3'd0;
      end else if (drive_rxc || !rcoe_n_q) begin
         hold_q <= 3'(PIN_SETTLE_CYC);
      end else if (hold_busy) begin
         hold_q <= hold_q - 3'd1;
      end
   end

   // partner clock activity, cleared when we drive the pin ourselves
   always_ff @(posedge mclk) begin
      if (srst) begin
         seen_q <= 1'b0;
      end else if (drive_rxc) begin
         seen_q <= 1'b0;
      end else if (rxc_rise && !hold_busy) begin
         seen_q <= 1'b1;
      end
   end

   assign rdata                  = rdata_q;
   assign jabber_enable          = jab_q;
   assign mac_full_duplex        = dup_q;
   assign tx_flow_enable         = txfc_q;
   assign rx_flow_enable         = rxfc_q;
   assign link_speed             = spd_q;
   assign rx_clock_delay_enable  = rxd_q;
   assign tx_clock_delay_enable  = txd_q;
   assign iface_type             = ift_q;
   assign clocks_from_partner    = cfp_q;
   assign storm_protect_en       = storm_q;
   assign payload_limit          = plim_q;
   assign back_pressure_en       = bp_q;
   assign frame_drop             = drop_q;
   assign frame_mirror_only      = mir_q;
   assign receive_clock_pin_out  = rcout_q;
   assign receive_clock_pin_oe_n = rcoe_n_q;
   assign link_clk_seen          = seen_q;
endmodule : port_link_mac_config
`default_nettype wire

// ---- test/plmc_chk_sva.sv ----
// port-level assertions for the config bank
// assumes it is bound into the bank and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module plmc_chk
   import port_cfg_pkg::*;
#(
   parameter logic [3:0] PORT_NUM = 4'h6
) (
   // clock, reset and register port
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   // pin, frame and control signals
   input wire logic        receive_clock_pin_out,
   input wire logic        receive_clock_pin_oe_n,
   input wire logic        frame_is_flow_ctrl,
   input wire logic        flow_ctrl_filter_en,
   input wire logic        mac_full_duplex,
   input wire logic        rx_clock_delay_enable,
   input wire logic        tx_clock_delay_enable,
   input wire logic [1:0]  iface_type,
   input wire logic        clocks_from_partner,
   input wire logic        storm_protect_en,
   input wire logic [13:0] payload_limit,
   input wire logic        back_pressure_en,
   input wire logic        frame_drop,
   input wire logic        link_clk_seen
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   wire logic mac0_wr = wr && addr == {PORT_NUM, OFS_MAC_CTRL0};

   chk_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   chk_other_port: assert property (rd && addr[15:12] != PORT_NUM |=> rdata == 8'h00)
      else $error("foreign port read returned data");
   chk_jumbo_on: assert property (mac0_wr && wdata[0] |-> ##2 payload_limit == PAYLOAD_JUMBO)
      else $error("jumbo limit not applied");
   chk_jumbo_off: assert property (mac0_wr && !wdata[0] |-> ##2 payload_limit == PAYLOAD_STD)
      else $error("standard limit not applied");
   chk_storm_write: assert property (mac0_wr |-> ##2 storm_protect_en == $past(wdata[1], 2))
      else $error("storm protection not following write");
   chk_bp_half: assert property (back_pressure_en |-> !mac_full_duplex)
      else $error("back pressure in full duplex");
   chk_delay_rgmii: assert property ((rx_clock_delay_enable || tx_clock_delay_enable)
      |-> iface_type == IF_RGMII)
      else $error("clock delay outside rgmii");
   chk_drive_dir: assert property ($fell(clocks_from_partner) && iface_type != IF_RGMII
      |-> ##[0:2] !receive_clock_pin_oe_n)
      else $error("clock pin not driven");
   chk_pin_toggle: assert property (!receive_clock_pin_oe_n [*2]
      |-> receive_clock_pin_out != $past(receive_clock_pin_out))
      else $error("driven clock pin stuck");
   chk_flow_filter: assert property (frame_is_flow_ctrl
      |=> frame_drop == $past(flow_ctrl_filter_en))
      else $error("flow frame filtering wrong");

   cover property (payload_limit == PAYLOAD_JUMBO);
   cover property (!receive_clock_pin_oe_n);
   cover property ($rose(link_clk_seen));
endmodule : plmc_chk

bind port_link_mac_config plmc_chk #(.PORT_NUM(PORT_NUM)) u_chk (
   .mclk, .srst, .addr, .wdata, .wr, .rd, .rdata,
   .receive_clock_pin_out, .receive_clock_pin_oe_n,
   .frame_is_flow_ctrl, .flow_ctrl_filter_en, .mac_full_duplex,
   .rx_clock_delay_enable, .tx_clock_delay_enable, .iface_type,
   .clocks_from_partner, .storm_protect_en, .payload_limit,
   .back_pressure_en, .frame_drop, .link_clk_seen
);
`default_nettype wire

// ---- test/link_partner_model.sv ----
// far-side clock source on the receive clock pin
// assumes the bank releases the pin by raising its enable_n
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
   // frame window and bank pin
   input  wire logic run,
   input  wire logic dut_out,
   input  wire logic dut_oe_n,
   // resolved pin
   output var  logic pin
);
   logic clk_q = 1'b0;
   // clock stands still outside frames, edges never align with mclk rising edges
   always begin
      #80;
      clk_q = run ? !clk_q : 1'b0;
   end
   assign pin = dut_oe_n ? clk_q : dut_out;
endmodule : link_partner_model
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the per-port config bank
// assumes the checker binds itself and the partner owns the clock pin
`timescale 1ns/1ps
`default_nettype none
module testbench
   import port_cfg_pkg::*;
;
   localparam logic [3:0] PN = 4'h6;
   logic        mclk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        phy_res_100 = 1'b0, phy_res_10 = 1'b0, phy_res_full = 1'b0;
   logic        flow_control_default_strap = 1'b0, port_speed_strap = 1'b0, port_clock_dir_strap = 1'b0;
   logic [1:0]  port_iface_type_strap = 2'b00;
   logic        frame_bad = 1'b0, frame_is_flow_ctrl = 1'b0, flow_ctrl_filter_en = 1'b0;
   logic [13:0] frame_payload_len = 14'd0;
   wire logic   receive_clock_pin_in, receive_clock_pin_out, receive_clock_pin_oe_n;
   wire logic [7:0] rdata;
   wire logic   jabber_enable, mac_full_duplex, tx_flow_enable, rx_flow_enable, rx_clock_delay_enable;
   wire logic   tx_clock_delay_enable, clocks_from_partner, storm_protect_en, back_pressure_en;
   wire logic   frame_drop, frame_mirror_only, link_clk_seen;
   wire logic [1:0]  link_speed, iface_type;
   wire logic [13:0] payload_limit;
   wire logic [26:0] got = {jabber_enable, mac_full_duplex, tx_flow_enable, rx_flow_enable, link_speed,
      rx_clock_delay_enable, tx_clock_delay_enable, iface_type, clocks_from_partner, storm_protect_en,
      payload_limit, back_pressure_en};
   integer      seed = 32'h9586;
   int          n_mismatch = 0, n_compared = 0;
   logic [7:0]  sh [6];
   logic [11:0] ofs [6] = '{OFS_PHY_CTRL_LO, OFS_PHY_CTRL_HI, OFS_EXT_CTRL0, OFS_EXT_CTRL1,
      OFS_MAC_CTRL0, OFS_MAC_CTRL1};
   logic [7:0]  wm [6] = '{8'h80, 8'hf3, 8'h7f, 8'hff, 8'h0b, 8'hbf};
   logic [13:0] lens [4] = '{14'd1500, 14'd1501, 14'd9000, 14'd9001};

   port_link_mac_config #(.PORT_NUM(PN), .HAS_PHY(1'b1), .HAS_EXT(1'b1)) u_dut (
      .mclk, .srst, .addr, .wdata, .wr, .rd, .rdata, .phy_res_100, .phy_res_10, .phy_res_full,
      .flow_control_default_strap, .port_speed_strap, .port_clock_dir_strap, .port_iface_type_strap,
      .receive_clock_pin_in, .receive_clock_pin_out, .receive_clock_pin_oe_n, .frame_bad,
      .frame_is_flow_ctrl, .flow_ctrl_filter_en, .frame_payload_len, .jabber_enable, .mac_full_duplex,
      .tx_flow_enable, .rx_flow_enable, .link_speed, .rx_clock_delay_enable, .tx_clock_delay_enable,
      .iface_type, .clocks_from_partner, .storm_protect_en, .payload_limit, .back_pressure_en,
      .frame_drop, .frame_mirror_only, .link_clk_seen);
   link_partner_model u_far (.run, .dut_out(receive_clock_pin_out), .dut_oe_n(receive_clock_pin_oe_n),
      .pin(receive_clock_pin_in));

   always #10 mclk = ~mclk;

   function automatic logic [7:0] view(int k);
      // status bits are live, bit 7 is the stored bit, the rest of the low phy byte reads zero
      return k == 0 ? (sh[0] & 8'h80) | {2'b00, phy_res_100, phy_res_10, phy_res_full, 3'b000} : sh[k];
   endfunction : view

   function automatic logic [26:0] exp_outs();
      logic [1:0] t;
      t = sh[3][1:0];
      // gigabit exists only on rgmii; other interfaces take the 10/100 bit
      return {sh[1][1], sh[2][6], sh[2][5], sh[2][3], (sh[3][6] || t != IF_RGMII) ? {1'b0, sh[2][4]} : 2'b10,
         sh[3][4] && t == IF_RGMII, sh[3][3] && t == IF_RGMII, t, sh[3][2], sh[4][1],
         sh[4][0] ? 14'd9000 : 14'd1500, sh[5][3] && !sh[2][6]};
   endfunction : exp_outs

   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic put(logic [15:0] a, logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : put

   task automatic get(logic [15:0] a, output logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : get

   task automatic wreg(int k, logic [7:0] d);
      put({PN, ofs[k]}, d);
      sh[k] = (sh[k] & ~wm[k]) | (d & wm[k]);
   endtask : wreg

   task automatic rchk(int k);
      logic [7:0] v;
      get({PN, ofs[k]}, v);
      cmp("register", view(k), v);
      cmp("controls", exp_outs(), got);
   endtask : rchk

   task automatic frame(logic b, logic fc, logic fe, logic [13:0] n);
      logic bad;
      @(posedge mclk);
      frame_bad          <= b;
      frame_is_flow_ctrl <= fc;
      flow_ctrl_filter_en <= fe;
      frame_payload_len  <= n;
      @(posedge mclk);
      #1 bad = b || n > (sh[4][0] ? 14'd9000 : 14'd1500);
      cmp("frame_drop", fc ? fe : bad && !sh[5][0], frame_drop);
      if (!fc) cmp("frame_mirror_only", bad && sh[5][0], frame_mirror_only);
   endtask : frame

   task automatic report_and_stop;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      logic [7:0]  v;
      logic [31:0] r;
      int          i;
      int          k;
      {flow_control_default_strap, port_speed_strap, port_clock_dir_strap, port_iface_type_strap} = $random(seed);
      sh = '{8'h00, 8'h03, {2'b01, flow_control_default_strap, 1'b1, flow_control_default_strap, 3'b000},
         {1'b0, port_speed_strap, 3'b001, port_clock_dir_strap, port_iface_type_strap}, 8'h00, 8'h00};
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      repeat (8) @(posedge mclk);
      cmp("link_clk_seen", 1'b0, link_clk_seen);
      for (k = 0; k < 6; k++) rchk(k);
      // rmii with the reference coming from the partner
      wreg(3, 8'h45);
      rchk(3);
      run <= 1'b1;
      for (i = 0; i < 100 && link_clk_seen !== 1'b1; i++) @(posedge mclk);
      run <= 1'b0;
      if (link_clk_seen !== 1'b1) begin
         n_mismatch++;
         report_and_stop;
      end
      cmp("receive_clock_pin_oe_n", 1'b1, receive_clock_pin_oe_n);
      for (k = 3; k >= 0; k--) begin
         wreg(3, {6'b010000, k[1:0]});
         rchk(3);
         cmp("receive_clock_pin_oe_n", k == 0, receive_clock_pin_oe_n);
      end
      for (k = 0; k < 6; k++) begin
         wreg(k, 8'hff);
         rchk(k);
         wreg(k, 8'h00);
         rchk(k);
      end
      repeat (40) begin
         k = $unsigned($random(seed)) % 6;
         {phy_res_100, phy_res_10, phy_res_full} <= $random(seed);
         wreg(k, $random(seed));
         rchk(k);
      end
      put({PN, 12'h302}, 8'hff);
      put({4'h5, OFS_MAC_CTRL0}, 8'hff);
      get({PN, 12'h302}, v);
      cmp("unmapped", 8'h00, v);
      get({4'h5, OFS_MAC_CTRL0}, v);
      cmp("other_port", 8'h00, v);
      rchk(4);
      for (int j = 0; j < 4; j++) begin
         wreg(4, {sh[4][7:1], j[0]});
         wreg(5, {sh[5][7:1], j[1]});
         for (int f = 0; f < 12; f++) begin
            r = $random(seed);
            frame(r[20] & r[23], r[21], r[22], f < 4 ? lens[f] : r[13:0] % 14'd9100);
         end
      end
      report_and_stop;
   end
endmodule : testbench
`default_nettype wire
